/* rtl/timer_capture_status.sv */
// Free-running counter, status flags, input capture and compare output with APB registers
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "timer_capture_defs.svh"

module timer_capture_status
    import timer_capture_pkg::*;
#(
    parameter int CNT_W = `TCS_CNT_WIDTH
)
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [9:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    // Timer pins
    input  wire logic        capture_input_pin_in,
    output logic             compare_output_pin_out,
    output logic             timer_irq_out
);

    // State struct fields are fixed at the documented counter width
    if (CNT_W != `TCS_CNT_WIDTH) begin : g_width_check
        $error("Counter width must equal the state struct counter width");
    end

    tcs_state_s s_r;
    tcs_state_s s_nxt;

    logic       setup;
    logic       acc_rd;
    logic       acc_wr;
    logic       mapped;
    logic [7:0] idx;
    logic       tick;
    logic       edge_seen;
    logic       cmp_hit;
    logic       ovf_hit;
    logic [7:0] flags_byte;
    logic [7:0] rd_byte;

    always_comb begin
        s_nxt      = s_r;
        setup      = psel_in && !penable_in;
        idx        = paddr_in[9:2];
        mapped     = (paddr_in[1:0] == `TCS_LOW_ADDR_BITS) &&
                     (idx >= `TCS_IDX_CONTROL) && (idx <= `TCS_IDX_ALT_LOW);
        acc_rd     = setup && !pwrite_in && mapped;
        acc_wr     = setup && pwrite_in && mapped;
        tick       = (s_r.presc == `TCS_PRESCALE_LAST);
        // Edge detection on the selected polarity
        edge_seen  = s_r.ctrl[`TCS_BIT_EDGE] ? (capture_input_pin_in && !s_r.cap_in_d)
                                             : (!capture_input_pin_in && s_r.cap_in_d);
        cmp_hit    = tick && !s_r.cmp_lock && (s_r.cmp_val == s_r.count);
        ovf_hit    = tick && (s_r.count == `TCS_CNT_TOP);
        flags_byte = {s_r.cap_flag, s_r.cmp_flag, s_r.ovf_flag, 5'h00};

        // Counter and prescaler
        s_nxt.presc    = s_r.presc + 2'h1;
        if (tick) begin
            s_nxt.count = s_r.count + 16'h0001;
        end
        s_nxt.cap_in_d = capture_input_pin_in;

        // Capture: sample counter at edge, transfer one clock later as count plus one
        s_nxt.cap_pend = 1'b0;
        if (edge_seen) begin
            s_nxt.cap_pend   = 1'b1;
            s_nxt.cap_sample = s_r.count + 16'h0001;
        end
        if (s_r.cap_pend && !s_r.cap_lock) begin
            s_nxt.cap_val = s_r.cap_sample;
        end

        // Default answer
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = `TCS_WORD_ZERO;
        rd_byte       = `TCS_BYTE_ZERO;

        // Any status access arms the overflow clear; only a status read arms the capture and compare clears
        if ((acc_rd || acc_wr) && idx == `TCS_IDX_FLAGS) begin
            if (s_r.ovf_flag) begin
                s_nxt.ovf_arm = 1'b1;
            end
            if (acc_rd) begin
                s_nxt.cap_arm = s_r.cap_flag;
                s_nxt.cmp_arm = s_r.cmp_flag;
            end
        end

        if (acc_rd) begin
            case (idx)
                `TCS_IDX_CONTROL: rd_byte = s_r.ctrl;
                `TCS_IDX_FLAGS:   rd_byte = flags_byte;
                `TCS_IDX_CAP_HIGH: begin
                    rd_byte        = s_r.cap_val[15:8];
                    s_nxt.cap_lock = 1'b1;
                end
                `TCS_IDX_CAP_LOW: begin
                    rd_byte        = s_r.cap_val[7:0];
                    s_nxt.cap_lock = 1'b0;
                    if (s_r.cap_arm) begin
                        s_nxt.cap_flag = 1'b0;
                        s_nxt.cap_arm  = 1'b0;
                    end
                end
                `TCS_IDX_CMP_HIGH: rd_byte = s_r.cmp_val[15:8];
                `TCS_IDX_CMP_LOW: begin
                    rd_byte = s_r.cmp_val[7:0];
                    if (s_r.cmp_arm) begin
                        s_nxt.cmp_flag = 1'b0;
                        s_nxt.cmp_arm  = 1'b0;
                    end
                end
                `TCS_IDX_CNT_HIGH: rd_byte = s_r.count[15:8];
                `TCS_IDX_CNT_LOW: begin
                    rd_byte = s_r.count[7:0];
                    if (s_r.ovf_arm) begin
                        s_nxt.ovf_flag = 1'b0;
                        s_nxt.ovf_arm  = 1'b0;
                    end
                end
                `TCS_IDX_ALT_HIGH: rd_byte = s_r.count[15:8];
                `TCS_IDX_ALT_LOW:  rd_byte = s_r.count[7:0];
                default:           rd_byte = `TCS_BYTE_ZERO;
            endcase
            s_nxt.prdata = {24'h000000, rd_byte};
        end

        if (acc_wr) begin
            case (idx)
                `TCS_IDX_CONTROL:  s_nxt.ctrl = pwdata_in[7:0] & `TCS_CTRL_MASK;
                `TCS_IDX_CMP_HIGH: begin
                    s_nxt.cmp_val[15:8] = pwdata_in[7:0];
                    s_nxt.cmp_lock      = 1'b1;
                end
                `TCS_IDX_CMP_LOW: begin
                    s_nxt.cmp_val[7:0] = pwdata_in[7:0];
                    s_nxt.cmp_lock     = 1'b0;
                end
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end

        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !mapped;
        end

        // Event sets win over clears
        if (s_r.cap_pend) begin
            s_nxt.cap_flag = 1'b1;
        end
        if (cmp_hit) begin
            s_nxt.cmp_flag  = 1'b1;
            s_nxt.pin_level = s_r.ctrl[`TCS_BIT_LEVEL];
        end
        if (ovf_hit) begin
            s_nxt.ovf_flag = 1'b1;
        end

        s_nxt.irq = (s_nxt.cap_flag && s_nxt.ctrl[`TCS_BIT_CAP]) ||
                    (s_nxt.cmp_flag && s_nxt.ctrl[`TCS_BIT_CMP]) ||
                    (s_nxt.ovf_flag && s_nxt.ctrl[`TCS_BIT_OVF]);
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r         <= '0;
            s_r.count   <= `TCS_CNT_RESET;
            s_r.cap_val <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready_out             = s_r.pready;
    assign prdata_out             = s_r.prdata;
    assign pslverr_out            = s_r.pslverr;
    assign compare_output_pin_out = s_r.pin_level;
    assign timer_irq_out          = s_r.irq;

endmodule

/* rtl/timer_capture_defs.svh */
// Register offsets, field positions and reset values of the capture/status timer block
`ifndef TIMER_CAPTURE_DEFS_SVH
`define TIMER_CAPTURE_DEFS_SVH

`define TCS_IDX_CONTROL      8'h12
`define TCS_IDX_FLAGS        8'h13
`define TCS_IDX_CAP_HIGH     8'h14
`define TCS_IDX_CAP_LOW      8'h15
`define TCS_IDX_CMP_HIGH     8'h16
`define TCS_IDX_CMP_LOW      8'h17
`define TCS_IDX_CNT_HIGH     8'h18
`define TCS_IDX_CNT_LOW      8'h19
`define TCS_IDX_ALT_HIGH     8'h1A
`define TCS_IDX_ALT_LOW      8'h1B

`define TCS_BIT_CAP          7
`define TCS_BIT_CMP          6
`define TCS_BIT_OVF          5
`define TCS_BIT_EDGE         1
`define TCS_BIT_LEVEL        0

`define TCS_CNT_WIDTH        16
`define TCS_CNT_RESET        16'hFFFC
`define TCS_CNT_TOP          16'hFFFF
`define TCS_PRESCALE_LAST    2'h3
`define TCS_CTRL_MASK        8'hE3
`define TCS_BYTE_ZERO        8'h00
`define TCS_WORD_ZERO        32'h0000_0000
`define TCS_LOW_ADDR_BITS    2'h0

`endif

/* rtl/timer_capture_pkg.sv */
// Types shared by the capture/status timer block
package timer_capture_pkg;
    typedef struct packed {
        logic [1:0]  presc;
        logic [15:0] count;
        logic [15:0] cap_val;
        logic        cap_lock;
        logic        cap_in_d;
        logic        cap_pend;
        logic [15:0] cap_sample;
        logic [15:0] cmp_val;
        logic        cmp_lock;
        logic [7:0]  ctrl;
        logic        cap_flag;
        logic        cmp_flag;
        logic        ovf_flag;
        logic        cap_arm;
        logic        cmp_arm;
        logic        ovf_arm;
        logic        pin_level;
        logic        irq;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } tcs_state_s;
endpackage

/* test/timer_capture_status_checker.sv */
// Port-level assertions for the capture/status timer
`timescale 1ns/1ps
`include "timer_capture_defs.svh"
module tcs_checker (
    input wire logic        clk_sys_in,
    input wire logic        rst_b_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [9:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    input wire logic        capture_input_pin_in,
    input wire logic        compare_output_pin_out,
    input wire logic        timer_irq_out
);
    logic [7:0]  ctl_r;
    logic [17:0] cnt_r;
    wire         setup = psel_in && !penable_in;
    wire [7:0]   idx   = paddr_in[9:2];
    wire         bad   = idx < `TCS_IDX_CONTROL || idx > `TCS_IDX_ALT_LOW || paddr_in[1:0] != 2'h0;
    // Shadow of control bits and of counter with its prescaler
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_r <= 8'h00;
            cnt_r <= {`TCS_CNT_RESET, 2'h0};
        end else begin
            cnt_r <= cnt_r + 18'h1;
            if (setup && pwrite_in && !bad && idx == `TCS_IDX_CONTROL) ctl_r <= pwdata_in[7:0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    a_ready_next: assert property (setup |=> pready_out) else $error("ready missing");
    a_err_unmapped: assert property (setup && bad |=> pslverr_out) else $error("error missing");
    a_err_data: assert property (pslverr_out |-> prdata_out == 32'h0) else $error("error data");
    a_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0) else $error("upper data");
    a_flags_low: assert property (setup && !pwrite_in && idx == `TCS_IDX_FLAGS |=> prdata_out[4:0] == 5'h00)
        else $error("flag low bits");
    a_count_read: assert property (setup && !pwrite_in && idx == `TCS_IDX_CNT_LOW |=> prdata_out[7:0] == $past(cnt_r[9:2]))
        else $error("count value");
    a_irq_gated: assert property (ctl_r[7:5] == 3'h0 && !(setup && pwrite_in) |=> !timer_irq_out)
        else $error("irq not gated");
    a_pin_level: assert property ($past(rst_b_in) && $changed(compare_output_pin_out)
        |-> compare_output_pin_out == $past(ctl_r[0])) else $error("pin level");
    c_cap_read: cover property (setup && idx == `TCS_IDX_CAP_HIGH);
    c_err: cover property (pslverr_out);
    c_pin: cover property ($rose(compare_output_pin_out));
endmodule

bind timer_capture_status tcs_checker chk_u (.clk_sys_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .capture_input_pin_in,
    .compare_output_pin_out, .timer_irq_out);

/* test/capture_source_model.sv */
// Source of the external capture signal
`timescale 1ns/1ps
module capture_source_model (
    output logic pin_out
);
    initial pin_out = 1'b0;
    // Called at a clock edge only
    task automatic drive(input logic lvl);
        pin_out <= lvl;
    endtask
endmodule

/* test/timer_capture_status_tb_top.sv */
// Self-checking testbench for the capture/status timer
`timescale 1ns/1ps
`include "timer_capture_defs.svh"
module timer_capture_status_tb_top;
    typedef struct {logic w; logic [7:0] idx; logic [7:0] wd; logic [31:0] exp; logic err;} row_s;
    logic        clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic        pready, pslverr, cmp_pin, irq, cap_pin, e;
    logic [15:0] a, b, x;
    int          cyc = 0, n_fail = 0, comparisons = 0;
    row_s rows [8] = '{'{1'b0, `TCS_IDX_CNT_HIGH, 8'h00, 32'hFF, 1'b0}, '{1'b1, `TCS_IDX_CMP_HIGH, 8'h80, 32'h0, 1'b0},
        '{1'b1, `TCS_IDX_CMP_LOW, 8'h00, 32'h0, 1'b0}, '{1'b1, `TCS_IDX_CONTROL, 8'hFF, 32'h0, 1'b0},
        '{1'b0, `TCS_IDX_CONTROL, 8'h00, 32'hE3, 1'b0}, '{1'b1, `TCS_IDX_CNT_LOW, 8'h55, 32'h0, 1'b0},
        '{1'b0, 8'h30, 8'h00, 32'h0, 1'b1}, '{1'b0, 8'h11, 8'h00, 32'h0, 1'b1}};
    timer_capture_status dut_u (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .capture_input_pin_in(cap_pin), .compare_output_pin_out(cmp_pin), .timer_irq_out(irq));
    capture_source_model src_u (.pin_out(cap_pin));
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rst_b) cyc <= cyc + 1;
    function automatic logic [15:0] cnt(input int k);
        return `TCS_CNT_RESET + 16'(k / 4);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i < 8 && pready !== 1'b1; i++) @(posedge clk_sys);
        chk(32'(pready), 32'h1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(d, exp);
    endtask
    // Edge of given polarity mid-count; returns expected capture
    task automatic cap(input logic pol, output logic [15:0] v);
        if (!pol) src_u.drive(1'b1);
        do @(posedge clk_sys); while (cyc % 4 != 1);
        src_u.drive(pol);
        v = cnt(cyc + 1) + 16'h1;
        @(posedge clk_sys);
        src_u.drive(1'b0);
    endtask
    task automatic test_done;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        chk(32'(irq) | 32'(cmp_pin) | prdata, 32'h0);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].idx, rows[i].wd);
            if (!rows[i].w) chk(d, rows[i].exp);
            chk(32'(e), 32'(rows[i].err));
        end
        chk(32'(irq), 32'h1);
        xfer(1'b1, `TCS_IDX_FLAGS, 8'hFF);
        xfer(1'b0, `TCS_IDX_ALT_LOW, 8'h00);
        chk(32'(irq), 32'h1);
        xfer(1'b0, `TCS_IDX_CNT_LOW, 8'h00);
        rd(`TCS_IDX_FLAGS, 32'h0);
        cap(1'b1, a);
        rd(`TCS_IDX_CAP_HIGH, 32'(a[15:8]));
        cap(1'b1, b);
        rd(`TCS_IDX_FLAGS, 32'h80);
        rd(`TCS_IDX_CAP_LOW, 32'(a[7:0]));
        rd(`TCS_IDX_FLAGS, 32'h0);
        cap(1'b1, a);
        cap(1'b1, b);
        rd(`TCS_IDX_FLAGS, 32'h80);
        rd(`TCS_IDX_CAP_HIGH, 32'(b[15:8]));
        rd(`TCS_IDX_CAP_LOW, 32'(b[7:0]));
        xfer(1'b1, `TCS_IDX_CONTROL, 8'hE1);
        cap(1'b0, a);
        rd(`TCS_IDX_FLAGS, 32'h80);
        rd(`TCS_IDX_CAP_HIGH, 32'(a[15:8]));
        rd(`TCS_IDX_CAP_LOW, 32'(a[7:0]));
        x = cnt(cyc) + 16'h8;
        xfer(1'b1, `TCS_IDX_CMP_HIGH, x[15:8]);
        xfer(1'b1, `TCS_IDX_CMP_LOW, x[7:0]);
        repeat (40) @(posedge clk_sys);
        chk(32'(cmp_pin), 32'h1);
        rd(`TCS_IDX_FLAGS, 32'h40);
        rd(`TCS_IDX_CMP_LOW, 32'(x[7:0]));
        rd(`TCS_IDX_FLAGS, 32'h0);
        test_done;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        test_done;
    end
endmodule
